// ---- logic/fdc_dma.sv ----
// Four-channel DMA controller core: host register file, hold handshake,
// priority selection and the four-state byte transfer sequencer.
// Assumes all pin inputs are synchronous to clk_sys and that an outside
// resolver combines the three-signal pins into wires.

`timescale 1ns/1ps
`default_nettype none

module fdc_dma
   import fdc_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        reset,
   input  wire logic        clk_en,
   input  wire logic        chip_select_n,
   input  wire logic [3:0]  addr_lo_in,
   output logic      [3:0]  addr_lo_out,
   output logic             addr_lo_oe,
   output logic      [3:0]  addr_mid_out,
   output logic             addr_mid_oe,
   input  wire logic [7:0]  data_in,
   output logic      [7:0]  data_out,
   output logic             data_oe,
   input  wire logic        port_read_strobe_n_in,
   output logic             port_read_strobe_n_out,
   output logic             port_read_strobe_oe,
   input  wire logic        port_write_strobe_n_in,
   output logic             port_write_strobe_n_out,
   output logic             port_write_strobe_oe,
   output logic             memory_read_strobe_n,
   output logic             memory_write_strobe_n,
   output logic             memory_strobe_oe,
   input  wire logic        ready,
   input  wire logic [3:0]  channel_request,
   output logic      [3:0]  channel_grant_n,
   output logic             bus_hold_request,
   input  wire logic        bus_hold_granted,
   output logic             address_drive_enable,
   output logic             upper_address_strobe,
   output logic             final_count_out,
   output logic             marker_out
);

   // ***************************************************************
   // State
   // ***************************************************************
   fdc_state_t  state;
   fdc_state_t  next_state;
   logic [15:0] chan_addr [CHANNELS];
   logic [15:0] chan_count [CHANNELS];
   logic [7:0]  mode;
   logic [7:0]  status;
   logic        byte_high;
   logic [1:0]  sel;
   logic [1:0]  prio_top;
   logic [7:0]  read_data;
   logic        rd_prev;
   logic        wr_prev;
   logic [7:0]  data_q;
   logic [3:0]  addr_q;
   logic        cs_q;

   // ***************************************************************
   // Slave access decode
   // ***************************************************************
   // Host access is locked out while the controller owns the bus.
   wire         in_cycle   = state inside {FDC_S1, FDC_S2, FDC_S3,
                                           FDC_SW, FDC_S4};
   wire         slave      = !in_cycle;
   wire         rd_active  = slave && !chip_select_n
                             && !port_read_strobe_n_in;
   // Writes are taken at the end of the strobe, with the data and
   // address seen in its last low cycle, so setup is honoured.
   wire         wr_done    = slave && cs_q && wr_prev
                             && port_write_strobe_n_in;
   wire         rd_done    = slave && cs_q && rd_prev
                             && port_read_strobe_n_in;
   wire         acc_mode   = addr_q[SEL_MODE_BIT];
   wire [1:0]   acc_ch     = addr_q[2:1];
   wire         acc_cnt    = addr_q[SEL_COUNT_BIT];
   wire         mode_wr    = wr_done && acc_mode;
   wire         chan_wr    = wr_done && !acc_mode;
   wire         status_rd  = rd_done && acc_mode;
   wire         chan_acc   = (wr_done || rd_done) && !acc_mode;
   wire [15:0]  acc_word   = acc_cnt ? chan_count[acc_ch]
                                     : chan_addr[acc_ch];
   wire [3:0]   cur_sel    = addr_lo_in[3:0];
   wire         cur_mode   = cur_sel[SEL_MODE_BIT];
   wire [15:0]  cur_word   = cur_sel[SEL_COUNT_BIT]
                             ? chan_count[cur_sel[2:1]]
                             : chan_addr[cur_sel[2:1]];
   wire [7:0]   next_read  = cur_mode ? status
                             : (byte_high ? cur_word[15:8]
                                          : cur_word[7:0]);

   // ***************************************************************
   // Priority selection
   // ***************************************************************
   // Masked channels drop out here.
   wire [3:0]   live_req   = channel_request & mode[3:0];
   wire         any_req    = |live_req;
   // S4 already skips the channel it served.
   wire [1:0]   after_sel  = sel + 2'h1;
   wire [1:0]   rot_top    = state == FDC_S4 ? after_sel : prio_top;
   wire [1:0]   top        = mode[MODE_ROTATE] ? rot_top : 2'h0;
   logic [1:0]  pick;

   // Scan from the current top channel; wraps round modulo four.
   always_comb
   begin
      logic [1:0] idx;
      idx  = 2'h0;
      pick = top;
      for (int i = CHANNELS - 1; i >= 0; i--)
      begin
         idx = top + 2'(i);
         if (live_req[idx])
            pick = idx;
      end
   end

   // ***************************************************************
   // Current channel view
   // ***************************************************************
   wire [15:0]  cur_addr   = chan_addr[sel];
   wire [1:0]   xfer_type  = chan_count[sel][TYPE_LSB +: 2];
   wire [13:0]  remaining  = chan_count[sel][COUNT_W-1:0];
   wire         is_verify  = xfer_type == TYPE_VERIFY;
   wire         is_read    = xfer_type == TYPE_READ;
   wire         is_write   = xfer_type == TYPE_WRITE;
   wire         last_byte  = remaining == '0;
   wire         early_wr   = mode[MODE_EARLY_WR];
   wire         stop_fc    = mode[MODE_STOP_FC];
   wire         reload_on  = mode[MODE_RELOAD];
   wire         do_reload  = reload_on && last_byte
                             && sel == RELOAD_DST;
   // Counts hold while the clock is off.
   wire         byte_end   = state == FDC_S4 && clk_en;
   // Stop-on-count masks only the continue test; the pick in S4 still sees the old enable.
   wire [3:0]   stop_mask  = (stop_fc && last_byte)
                             ? 4'(1) << sel : 4'h0;
   wire [3:0]   cont_req   = live_req & ~stop_mask;

   // ***************************************************************
   // Sequencer next state
   // ***************************************************************
   always_comb
   begin
      next_state = state;
      unique case (state)
         FDC_IDLE:
            if (any_req)
               next_state = FDC_S0;
         FDC_S0:
            if (!any_req)
               next_state = FDC_IDLE;
            else if (bus_hold_granted)
               next_state = FDC_S1;
         FDC_S1:
            next_state = FDC_S2;
         FDC_S2:
            next_state = FDC_S3;
         FDC_S3:
            // Verify has no memory access to stretch.
            if (!is_verify && !ready)
               next_state = FDC_SW;
            else
               next_state = FDC_S4;
         FDC_SW:
            if (ready)
               next_state = FDC_S4;
         FDC_S4:
            if (bus_hold_granted && |cont_req)
               next_state = FDC_S1;
            else
               next_state = FDC_IDLE;
      endcase
   end

   // ***************************************************************
   // Sequencer and channel selection registers
   // ***************************************************************
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         state    <= FDC_IDLE;
         sel      <= 2'h0;
         prio_top <= 2'h0;
      end
      else if (clk_en)
      begin
         state <= next_state;
         if ((state == FDC_S0 && bus_hold_granted) || state == FDC_S4)
            sel <= pick;
         if (state == FDC_S4)
            prio_top <= sel + 2'h1;
      end
   end

   // ***************************************************************
   // Host side capture and byte toggle
   // ***************************************************************
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         rd_prev   <= 1'b0;
         wr_prev   <= 1'b0;
         cs_q      <= 1'b0;
         data_q    <= 8'h00;
         addr_q    <= 4'h0;
         byte_high <= 1'b0;
         read_data <= 8'h00;
      end
      else if (clk_en)
      begin
         rd_prev   <= rd_active;
         wr_prev   <= slave && !chip_select_n && !port_write_strobe_n_in;
         if (!port_write_strobe_n_in || !port_read_strobe_n_in)
         begin
            cs_q   <= !chip_select_n;
            addr_q <= addr_lo_in;
            data_q <= data_in;
         end
         read_data <= next_read;
         // A mode write restarts the pairing at the low byte.
         if (mode_wr)
            byte_high <= 1'b0;
         else if (chan_acc)
            byte_high <= !byte_high;
      end
   end

   // ***************************************************************
   // Channel registers: host writes, per-byte update, auto reload
   // ***************************************************************
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         for (int c = 0; c < CHANNELS; c++)
         begin
            chan_addr[c]  <= CHAN_RESET;
            chan_count[c] <= CHAN_RESET;
         end
      end
      else if (clk_en)
      begin
         if (chan_wr && !acc_cnt)
         begin
            if (byte_high)
               chan_addr[acc_ch][15:8] <= data_q;
            else
               chan_addr[acc_ch][7:0] <= data_q;
         end
         if (chan_wr && acc_cnt)
         begin
            if (byte_high)
               chan_count[acc_ch][15:8] <= data_q;
            else
               chan_count[acc_ch][7:0] <= data_q;
         end
         if (byte_end && do_reload)
         begin
            chan_addr[RELOAD_DST]  <= chan_addr[RELOAD_SRC];
            chan_count[RELOAD_DST] <= chan_count[RELOAD_SRC];
         end
         else if (byte_end)
         begin
            chan_addr[sel] <= cur_addr + 16'h0001;
            chan_count[sel][COUNT_W-1:0] <= remaining - 14'h0001;
         end
      end
   end

   // ***************************************************************
   // Mode and status registers
   // ***************************************************************
   // Status flags clear when read; an event in the same cycle wins.
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         mode   <= MODE_RESET;
         status <= STATUS_RESET;
      end
      else if (clk_en)
      begin
         if (mode_wr)
            mode <= data_q;
         else if (byte_end)
            mode[3:0] <= mode[3:0] & ~stop_mask;
         status <= status_rd ? STATUS_RESET : status;
         if (byte_end && last_byte)
         begin
            status[sel] <= 1'b1;
            if (do_reload)
               status[STAT_RELOAD] <= 1'b1;
         end
      end
   end

   // ***************************************************************
   // Bus and strobe outputs
   // ***************************************************************
   wire st_s2on  = state inside {FDC_S2, FDC_S3, FDC_SW, FDC_S4};
   wire st_s3on  = state inside {FDC_S3, FDC_SW, FDC_S4};
   wire wr_on    = early_wr ? st_s2on : st_s3on;
   wire rd_on    = st_s2on;

   // Hold request stays up from the first request to the end of service.
   assign bus_hold_request     = state != FDC_IDLE;
   assign address_drive_enable = in_cycle;
   assign upper_address_strobe = state == FDC_S1;
   assign addr_lo_oe           = in_cycle;
   assign addr_lo_out          = cur_addr[3:0];
   assign addr_mid_oe          = in_cycle;
   assign addr_mid_out         = cur_addr[7:4];
   // High address goes on the data bus only for the external latch.
   assign data_oe              = upper_address_strobe || rd_active;
   assign data_out             = upper_address_strobe ? cur_addr[15:8]
                                                      : read_data;
   assign memory_strobe_oe     = in_cycle;
   assign port_read_strobe_oe  = in_cycle;
   assign port_write_strobe_oe = in_cycle;
   // Verify mode leaves every strobe idle.
   assign memory_read_strobe_n    = !(rd_on && is_read);
   assign port_read_strobe_n_out  = !(rd_on && is_write);
   assign memory_write_strobe_n   = !(wr_on && is_write);
   assign port_write_strobe_n_out = !(wr_on && is_read);
   // Type eleven still runs a cycle, unstrobed.
   assign channel_grant_n = st_s2on ? ~(4'(1) << sel) : 4'hF;
   assign final_count_out = st_s3on && last_byte;
   assign marker_out      = state == FDC_S3
                            && remaining[6:0] == MARKER_PHASE;

endmodule

`default_nettype wire

// ---- logic/fdc_pkg.sv ----
// Constants, field layouts and states of the four-channel DMA controller.
// Assumes a single synchronous clock domain and synchronous pin inputs.
//
// Behaviour
// - Low four address pins select registers as slave, drive address as master.
// - Next four address pins output memory address bits 4 to 7 in DMA.
// - Four channels, each with 16-bit address and count, byte-wise, low first.
// - Count top two bits pick verify, write, read; eleven is not allowed.
// - Verify mode drives no read or write strobes and ignores ready.
// - Mode register: upper nibble option bits, lower nibble channel enables.
// - Reset clears mode and status registers, disabling every channel.
// - Request on an enabled channel raises hold request and enters S0.
// - On grant, priority logic picks the highest requesting channel.
// - In S1 drive low address on pins, high byte on data, enable address.
// - In S2 assert read strobe, early write if on, and channel grant.
// - In S3 assert write strobe; final count when remaining count is zero.
// - In S3 pulse the marker at each 128-byte boundary.
// - Ready is sampled in S3; low inserts wait states.
// - S4 holds address, strobes, grant and decides whether to continue.
// - Auto reload copies channel 3 registers into channel 2 at its end.
// - Early write option asserts write strobes one state earlier.
// - Stop-on-final-count clears the channel enable at final count.
// - Rotating priority makes the served channel lowest after each byte.
// - Byte toggle flips after each channel register byte access.
// - Status holds one final-count flag per channel.
// - Status holds a reload flag set when channel 3 reloads channel 2.

package fdc_pkg;

   // ***************************************************************
   // Register addressing and layouts
   // ***************************************************************
   localparam int          CHANNELS        = 4;
   localparam int          SEL_MODE_BIT    = 3;   // Pin 3 high: mode/status
   localparam int          SEL_COUNT_BIT   = 0;   // Pin 0 high: count reg
   localparam int          COUNT_W         = 14;
   localparam int          TYPE_LSB        = 14;
   localparam logic [1:0]  TYPE_VERIFY     = 2'h0;
   localparam logic [1:0]  TYPE_WRITE      = 2'h1;
   localparam logic [1:0]  TYPE_READ       = 2'h2;
   localparam int          MODE_ROTATE     = 4;
   localparam int          MODE_EARLY_WR   = 5;
   localparam int          MODE_STOP_FC    = 6;
   localparam int          MODE_RELOAD     = 7;
   localparam int          STAT_RELOAD     = 4;
   localparam logic [7:0]  MODE_RESET      = 8'h00;
   localparam logic [7:0]  STATUS_RESET    = 8'h00;
   localparam logic [15:0] CHAN_RESET      = 16'h0000;
   localparam logic [6:0]  MARKER_PHASE    = 7'h00;
   localparam logic [1:0]  RELOAD_DST      = 2'h2;
   localparam logic [1:0]  RELOAD_SRC      = 2'h3;

   // ***************************************************************
   // Transfer sequencer states
   // ***************************************************************
   typedef enum logic [2:0] {
      FDC_IDLE,
      FDC_S0,
      FDC_S1,
      FDC_S2,
      FDC_S3,
      FDC_SW,
      FDC_S4
   } fdc_state_t;

endpackage

// ---- testbench/fdc_dma_assertions.sv ----
// Port checks on DMA cycle framing, grants and count flags.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module fdc_dma_checker
(
   input wire logic       clk_sys,
   input wire logic       reset,
   input wire logic       addr_lo_oe,
   input wire logic       addr_mid_oe,
   input wire logic       memory_strobe_oe,
   input wire logic [3:0] addr_lo_out,
   input wire logic [3:0] addr_mid_out,
   input wire logic       data_oe,
   input wire logic       memory_read_strobe_n,
   input wire logic       memory_write_strobe_n,
   input wire logic [3:0] channel_grant_n,
   input wire logic       bus_hold_request,
   input wire logic       bus_hold_granted,
   input wire logic       address_drive_enable,
   input wire logic       upper_address_strobe,
   input wire logic       final_count_out,
   input wire logic       marker_out
);
   // ***************************************************************
   // Cycle framing, grants and flags
   // ***************************************************************
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   // Reset must idle the bus whatever state it interrupts
   a_reset_idle:
      assert property (disable iff (1'b0) reset |=> !bus_hold_request
         && !address_drive_enable && channel_grant_n == 4'hf)
      else $error("outputs not idle after reset");
   a_pins_owned:
      assert property ({addr_lo_oe, addr_mid_oe, memory_strobe_oe} ==
         {3{address_drive_enable}})
      else $error("address pins not driven with the cycle");
   a_cycle_needs_hold:
      assert property ($rose(address_drive_enable) |-> bus_hold_request
         && $past(bus_hold_granted))
      else $error("cycle began without a granted hold");
   a_first_state:
      assert property (upper_address_strobe |-> (address_drive_enable
         && data_oe) ##1 (!upper_address_strobe && channel_grant_n != 4'hf))
      else $error("first state framing wrong");
   a_four_states:
      assert property ($rose(address_drive_enable) |->
         address_drive_enable[*4])
      else $error("byte shorter than four states");
   a_one_grant:
      assert property ($onehot0(~channel_grant_n))
      else $error("more than one channel granted");
   // Address holds from the first state to the end of a byte
   a_addr_held:
      assert property (address_drive_enable && !upper_address_strobe |->
         $stable(addr_lo_out) && $stable(addr_mid_out))
      else $error("address moved within a byte");
   a_no_dual_strobe:
      assert property (!(!memory_read_strobe_n && !memory_write_strobe_n))
      else $error("memory read and write together");
   a_count_flags:
      assert property (final_count_out || marker_out |-> address_drive_enable
         && !upper_address_strobe && channel_grant_n != 4'hf)
      else $error("count flag outside the late states");
   c_final: cover property (final_count_out);
   c_marker: cover property (marker_out);
   c_byte: cover property ($rose(address_drive_enable));
endmodule

bind fdc_dma fdc_dma_checker chk (
   .clk_sys(clk_sys), .reset(reset), .addr_lo_oe(addr_lo_oe),
   .addr_mid_oe(addr_mid_oe), .memory_strobe_oe(memory_strobe_oe),
   .addr_lo_out(addr_lo_out), .addr_mid_out(addr_mid_out),
   .data_oe(data_oe), .memory_read_strobe_n(memory_read_strobe_n),
   .memory_write_strobe_n(memory_write_strobe_n),
   .channel_grant_n(channel_grant_n), .bus_hold_request(bus_hold_request),
   .bus_hold_granted(bus_hold_granted),
   .address_drive_enable(address_drive_enable),
   .upper_address_strobe(upper_address_strobe),
   .final_count_out(final_count_out), .marker_out(marker_out));
`default_nettype wire

// ---- testbench/fdc_host_model.sv ----
// CPU and memory model: grants the bus, answers ready with waits.
// Assumes the bench resolves the shared strobe pins into wires.
`timescale 1ns/1ps
`default_nettype none
module fdc_host_model
(
   input  wire logic       clk_sys,
   input  wire logic       reset,
   input  wire logic       bus_hold_request,
   input  wire logic       any_strobe_n,
   input  wire logic [3:0] wait_n,
   input  wire logic       stall,
   output logic            bus_hold_granted,
   output logic            ready
);
   logic [3:0] lag;
   logic [3:0] since;

   // Grant lags two cycles, as the CPU first ends its instruction
   always_ff @(posedge clk_sys)
   begin
      lag <= (reset || !bus_hold_request) ? 4'h0 : lag + {3'h0, lag < 4'h2};
      since <= any_strobe_n ? 4'h0 : since + {3'h0, since != 4'hf};
   end
   assign bus_hold_granted = bus_hold_request && lag == 4'h2;
   // Slow memory: ready low for the first wait_n cycles of a strobe
   assign ready = !stall && (any_strobe_n || since >= wait_n);
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench for the four-channel DMA controller.
// Assumes the package, design, checker and model compile first.
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import fdc_pkg::*;
;
   logic       clk_sys = 1'b0;
   logic       reset   = 1'b1;
   logic       cs_n    = 1'b1;
   logic       h_rd_n  = 1'b1;
   logic       h_wr_n  = 1'b1;
   logic       stall   = 1'b0;
   logic [3:0] h_addr  = 4'h0;
   logic [3:0] req     = 4'h0;
   logic [3:0] wait_n  = 4'h0;
   logic [7:0] h_data  = 8'h00;
   int         errors  = 0;
   int         checks  = 0;
   int         cycles  = 0;
   logic [3:0] a_lo, a_mid, gnt_n;
   logic [7:0] d_out;
   logic       a_oe, d_oe, prd, prd_oe, pwr, pwr_oe, mrd_n, mwr_n;
   logic       hold_req, hold_ok, rdy, drv_en, up_stb, fin, mk;
   // Shared pins: whoever enables its driver sets the level
   wire  [3:0] a_pin   = a_oe ? a_lo : h_addr;
   wire  [7:0] d_pin   = d_oe ? d_out : h_data;
   wire        prd_pin = prd_oe ? prd : h_rd_n;
   wire        pwr_pin = pwr_oe ? pwr : h_wr_n;

   fdc_dma dut (
      .clk_sys(clk_sys), .reset(reset), .clk_en(1'b1), .chip_select_n(cs_n),
      .addr_lo_in(a_pin), .addr_lo_out(a_lo), .addr_lo_oe(a_oe),
      .addr_mid_out(a_mid), .addr_mid_oe(), .data_in(d_pin),
      .data_out(d_out), .data_oe(d_oe), .port_read_strobe_n_in(prd_pin),
      .port_read_strobe_n_out(prd), .port_read_strobe_oe(prd_oe),
      .port_write_strobe_n_in(pwr_pin), .port_write_strobe_n_out(pwr),
      .port_write_strobe_oe(pwr_oe), .memory_read_strobe_n(mrd_n),
      .memory_write_strobe_n(mwr_n), .memory_strobe_oe(), .ready(rdy),
      .channel_request(req), .channel_grant_n(gnt_n),
      .bus_hold_request(hold_req), .bus_hold_granted(hold_ok),
      .address_drive_enable(drv_en), .upper_address_strobe(up_stb),
      .final_count_out(fin), .marker_out(mk));
   fdc_host_model cpu (
      .clk_sys(clk_sys), .reset(reset), .bus_hold_request(hold_req),
      .any_strobe_n(mrd_n & mwr_n & prd_pin & pwr_pin), .wait_n(wait_n),
      .stall(stall), .bus_hold_granted(hold_ok), .ready(rdy));

   // ***************************************************************
   // Clock, timeout and shared tasks
   // ***************************************************************
   always #2.5 clk_sys = ~clk_sys;
   // Cut a hang short; the full run needs about 700 cycles
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         errors++;
         $display("MISMATCH at %0t: run timed out", $time);
         wrap_up();
      end
   end
   task automatic step();
      @(posedge clk_sys);
      #1;
   endtask
   task automatic chk(input logic [15:0] got, exp, input string what);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // Host write: strobe low one cycle, the byte lands on the rising edge
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      cs_n = 1'b0;
      h_addr = a;
      h_data = d;
      h_wr_n = 1'b0;
      step();
      h_wr_n = 1'b1;
      step();
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] exp,
                     input string what);
      cs_n = 1'b0;
      h_addr = a;
      h_rd_n = 1'b0;
      repeat (2) step();
      chk({8'h00, d_out}, exp, what);
      h_rd_n = 1'b1;
      step();
   endtask
   // Low byte first; the byte toggle picks the half
   task automatic prog(input logic [1:0] c, input logic [15:0] ad, cn);
      wr({1'b0, c, 1'b0}, ad[7:0]);
      wr({1'b0, c, 1'b0}, ad[15:8]);
      wr({1'b0, c, 1'b1}, cn[7:0]);
      wr({1'b0, c, 1'b1}, cn[15:8]);
   endtask
   task automatic wait_s1();
      int n = 0;
      while (up_stb !== 1'b1 && n < 100)
      begin
         step();
         n++;
      end
      chk({15'h0, up_stb}, 16'h1, "cycle start");
   endtask
   // Steps from the third state until the next byte or idle
   task automatic gap(input int want, input string what);
      int n = 0;
      while (drv_en === 1'b1 && up_stb !== 1'b1 && n < 20)
      begin
         step();
         n++;
      end
      chk(16'(n), 16'(want), what);
   endtask
   // Follows one byte to the third state
   task automatic xfer(input logic [1:0] c, input logic [15:0] ad,
                       input logic [1:0] ty, input logic early, fx, mx);
      logic r = (ty == TYPE_READ);
      logic w = (ty == TYPE_WRITE);
      wait_s1();
      chk({d_out, a_mid, a_lo}, ad, "address");
      step();
      chk({12'h0, gnt_n}, {12'h0, ~(4'h1 << c)}, "grant");
      chk({12'h0, mrd_n, prd, pwr, mwr_n},
          {12'h0, !r, !w, !(r && early), !(w && early)}, "second strobes");
      step();
      chk({12'h0, mrd_n, prd, pwr, mwr_n},
          {12'h0, !r, !w, !r, !w}, "third strobes");
      chk({14'h0, fin, mk}, {14'h0, fx, mx}, "flags");
   endtask

   // ***************************************************************
   // Scenarios
   // ***************************************************************
   task automatic t_regs();
      rd(4'h8, 16'h0000, "status after reset");
      prog(2'h0, 16'ha55a, 16'h8003);
      rd(4'h0, 16'h005a, "address low");
      rd(4'h0, 16'h00a5, "address high");
      req = 4'h1;
      repeat (6) step();
      chk({15'h0, hold_req}, 16'h0, "disabled channel");
      req = 4'h0;
      $display("test registers done");
   endtask
   task automatic t_read();
      prog(2'h0, 16'h12ff, 16'h8001);
      wait_n = 4'h3;
      wr(4'h8, 8'h21);
      req = 4'h1;
      xfer(2'h0, 16'h12ff, TYPE_READ, 1'b1, 1'b0, 1'b0);
      gap(4, "wait states");
      xfer(2'h0, 16'h1300, TYPE_READ, 1'b1, 1'b1, 1'b1);
      req = 4'h0;
      wait_n = 4'h0;
      repeat (6) step();
      chk({15'h0, hold_req}, 16'h0, "hold released");
      rd(4'h8, 16'h0001, "final count flag");
      $display("test read done");
   endtask
   task automatic t_mark();
      prog(2'h1, 16'h0200, 16'h4081);
      wr(4'h8, 8'h42);
      req = 4'h2;
      for (int k = 0; k < 130; k++)
         xfer(2'h1, 16'h0200 + 16'(k), TYPE_WRITE, 1'b0,
              k == 129, k == 1 || k == 129);
      repeat (6) step();
      chk({15'h0, hold_req}, 16'h0, "stop on count");
      req = 4'h0;
      rd(4'h8, 16'h0002, "channel 1 flag");
      $display("test marker done");
   endtask
   task automatic t_prio();
      logic [3:0] prev;
      logic [3:0] nxt;
      prog(2'h0, 16'h0000, 16'h0007);
      prog(2'h1, 16'h0100, 16'h0007);
      prog(2'h2, 16'h0200, 16'h0007);
      stall = 1'b1;
      wr(4'h8, 8'h07);
      req = 4'h7;
      xfer(2'h0, 16'h0000, TYPE_VERIFY, 1'b0, 1'b0, 1'b0);
      xfer(2'h0, 16'h0001, TYPE_VERIFY, 1'b0, 1'b0, 1'b0);
      req = 4'h0;
      gap(2, "verify ignores ready");
      repeat (6) step();
      wr(4'h8, 8'h17);
      req = 4'h7;
      wait_s1();
      step();
      prev = ~gnt_n;
      repeat (3)
      begin
         wait_s1();
         step();
         nxt = (prev == 4'h4) ? 4'h1 : prev << 1;
         chk({12'h0, ~gnt_n}, {12'h0, nxt}, "rotation");
         prev = ~gnt_n;
      end
      req = 4'h0;
      stall = 1'b0;
      repeat (8) step();
      $display("test priority done");
   endtask
   task automatic t_reload();
      prog(2'h2, 16'h3000, 16'h8000);
      prog(2'h3, 16'h4000, 16'h8001);
      wr(4'h8, 8'h84);
      req = 4'h4;
      xfer(2'h2, 16'h3000, TYPE_READ, 1'b0, 1'b1, 1'b1);
      xfer(2'h2, 16'h4000, TYPE_READ, 1'b0, 1'b0, 1'b0);
      req = 4'h0;
      repeat (6) step();
      rd(4'h8, 16'h0014, "reload flags");
      $display("test reload done");
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial
   begin
      repeat (6) @(posedge clk_sys);
      #1;
      reset = 1'b0;
      step();
      t_regs();
      t_read();
      t_mark();
      t_prio();
      t_reload();
      wrap_up();
   end
endmodule
`default_nettype wire
